// ==== led_cfg_pkg.sv ====
// constants and field layout shared by the led indicator configuration block
//
// Function
// - two-bit blink rate: 50, 100, 200, 500 ms
// - source code 0000b shows link up
// - codes 1-3 blink on rx/tx, tx, rx
// - codes 4/5 light on link as master/slave
// - code 6 stretched activity; 7, 8 reserved
// - code 9 latches link loss until status read
// - code 10 latches prbs error until cleared
// - code 11 shows stretched mac interface errors
// - compliance selector steers led 0 at mux 5
// - compliance codes 0-5 pick six status signals
// - manual drive enable overrides the led level, except led 0 at mux 5
// - manual value matters only while enable set
// - led 0 mux value 101b shows compliance signal
package led_cfg_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map
   localparam logic [15:0] SRC_CFG_ADDR  = 16'h0450;
   localparam logic [15:0] DRV_CFG_ADDR  = 16'h0451;
   localparam logic [15:0] SRC_CFG_RST   = 16'h2610;
   localparam logic [15:0] DRV_CFG_RST   = 16'h0000;
   localparam logic [15:0] SRC_CFG_WMASK = 16'h7fff;
   localparam logic [15:0] DRV_CFG_WMASK = 16'h0fff;

   // field positions
   localparam int BYPASS_BIT    = 14;
   localparam int RATE_LSB      = 12;
   localparam int OPT_W         = 4;
   localparam int COMPL_LSB     = 9;
   localparam int LED_STRIDE    = 3;
   localparam int POL_OFS       = 0;
   localparam int VAL_OFS       = 1;
   localparam int EN_OFS        = 2;
   localparam int NUM_LEDS      = 3;

   // led source codes
   localparam logic [3:0] SRC_LINK      = 4'h0;
   localparam logic [3:0] SRC_LINK_TRX  = 4'h1;
   localparam logic [3:0] SRC_LINK_TX   = 4'h2;
   localparam logic [3:0] SRC_LINK_RX   = 4'h3;
   localparam logic [3:0] SRC_MASTER    = 4'h4;
   localparam logic [3:0] SRC_SLAVE     = 4'h5;
   localparam logic [3:0] SRC_ACT_STR   = 4'h6;
   localparam logic [3:0] SRC_LINK_LOST = 4'h9;
   localparam logic [3:0] SRC_PRBS_ERR  = 4'ha;
   localparam logic [3:0] SRC_MAC_ERR   = 4'hb;

   // led 0 pin multiplexer code that selects compliance observation
   localparam logic [2:0] MUX_COMPLIANCE = 3'h5;
   localparam int         NUM_COMPL      = 6;

   ////////////////////////////////////////////////////////////////////////////
   // timing, clock at 125 MHz
   localparam int CLK_KHZ        = 125000;
   localparam int BLINK_MS_20HZ  = 50;
   localparam int BLINK_MS_10HZ  = 100;
   localparam int BLINK_MS_5HZ   = 200;
   localparam int BLINK_MS_2HZ   = 500;
   // each blink period is split into an on half and an off half
   localparam int BLINK_HALF_20HZ = BLINK_MS_20HZ * CLK_KHZ / 2;
   localparam int BLINK_HALF_10HZ = BLINK_MS_10HZ * CLK_KHZ / 2;
   localparam int BLINK_HALF_5HZ  = BLINK_MS_5HZ * CLK_KHZ / 2;
   localparam int BLINK_HALF_2HZ  = BLINK_MS_2HZ * CLK_KHZ / 2;
   localparam int STRETCH_MS      = 50;
   localparam int STRETCH_CYC     = STRETCH_MS * CLK_KHZ;
   localparam int CNT_W           = 26;

endpackage : led_cfg_pkg

// ==== led_time_if.sv ====
// blink timebase signals between the timebase and the led logic
`timescale 1ns/1ns
interface led_time_if;
   logic [1:0] rate;
   logic       blink_phase;
   logic       blink_wrap;

   modport gen (input rate, output blink_phase, output blink_wrap);
   modport use_side (output rate, input blink_phase, input blink_wrap);
endinterface : led_time_if

// ==== led_blink_timebase.sv ====
// blink phase generator with a selectable half period
`timescale 1ns/1ns
module led_blink_timebase
   import led_cfg_pkg::*;
#(
   parameter int HALF_20HZ = BLINK_HALF_20HZ,
   parameter int HALF_10HZ = BLINK_HALF_10HZ,
   parameter int HALF_5HZ  = BLINK_HALF_5HZ,
   parameter int HALF_2HZ  = BLINK_HALF_2HZ
) (
   input  wire logic  clk_sys_i,
   input  wire logic  rst_i,
   led_time_if.gen    tb
);
   import led_cfg_pkg::*;

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] limit;
   logic             phase_q;

   // half period for the selected rate, minus one for the terminal count
   always_comb
   begin
      unique case (tb.rate)
         2'b00: limit = CNT_W'(HALF_20HZ - 1);
         2'b01: limit = CNT_W'(HALF_10HZ - 1);
         2'b10: limit = CNT_W'(HALF_5HZ - 1);
         2'b11: limit = CNT_W'(HALF_2HZ - 1);
      endcase
   end

   // >= rather than == so a rate cut mid-count wraps at once instead of
   // running the full counter range
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         cnt_q   <= '0;
         phase_q <= 1'b1;
      end
      else if (cnt_q >= limit)
      begin
         cnt_q   <= '0;
         phase_q <= ~phase_q;
      end
      else
      begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   assign tb.blink_phase = phase_q;
   assign tb.blink_wrap  = (cnt_q >= limit);

endmodule : led_blink_timebase

// ==== led_indicator_config.sv ====
// led indicator source selection, blink, stretch, override and polarity
`timescale 1ns/1ns
module led_indicator_config
   import led_cfg_pkg::*;
#(
   parameter int HALF_20HZ   = led_cfg_pkg::BLINK_HALF_20HZ,
   parameter int HALF_10HZ   = led_cfg_pkg::BLINK_HALF_10HZ,
   parameter int HALF_5HZ    = led_cfg_pkg::BLINK_HALF_5HZ,
   parameter int HALF_2HZ    = led_cfg_pkg::BLINK_HALF_2HZ,
   parameter int STRETCH_LEN = led_cfg_pkg::STRETCH_CYC
) (
   input  wire logic                              clk_sys_i,
   input  wire logic                              rst_i,
   // register port
   input  wire logic [15:0]                       reg_addr_i,
   input  wire logic [15:0]                       reg_wdata_i,
   input  wire logic                              reg_wr_i,
   input  wire logic                              reg_rd_i,
   output logic      [15:0]                       reg_rdata_o,
   // phy core status
   input  wire logic                              link_up_i,
   input  wire logic                              tx_act_i,
   input  wire logic                              rx_act_i,
   input  wire logic                              phy_master_i,
   input  wire logic                              status_read_i,
   input  wire logic                              prbs_err_i,
   input  wire logic                              prbs_clr_i,
   input  wire logic                              mac_tx_err_i,
   input  wire logic                              mac_rx_err_i,
   input  wire logic [led_cfg_pkg::NUM_COMPL-1:0] compl_status_i,
   input  wire logic [2:0]                        led0_mux_ctrl_i,
   // led pins
   output logic      [led_cfg_pkg::NUM_LEDS-1:0]  led_o
);
   import led_cfg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic [15:0]          src_cfg_q;
   logic [15:0]          drv_cfg_q;
   logic [15:0]          rdata_q;
   logic                 link_prev_q;
   logic                 link_lost_q;
   logic                 prbs_latch_q;
   logic [2:0]           act_seen_q;
   logic [CNT_W-1:0]     str_cnt_q [2];
   logic [1:0]           str_evt;
   logic [1:0]           str_out;
   logic                 bypass;
   logic [2:0]           compl_sel;
   logic                 compl_bit;
   logic [NUM_LEDS-1:0]  led_norm;
   logic [NUM_LEDS-1:0]  led_d;
   logic [NUM_LEDS-1:0]  led_q;

   led_time_if tb_if ();

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // option field of one led
   function automatic logic [3:0] led_option(input logic [15:0] cfg, input int idx);
      led_option = cfg[idx*OPT_W +: OPT_W];
   endfunction : led_option

   // one bit of a led's drive and polarity group
   function automatic logic drv_bit(input logic [15:0] cfg, input int idx, input int ofs);
      drv_bit = cfg[idx*LED_STRIDE + ofs];
   endfunction : drv_bit

   // blink the steady link light while activity was seen this blink cycle
   function automatic logic link_blink(input logic link, input logic seen,
                                       input logic phase);
      link_blink = link & (~seen | phase);
   endfunction : link_blink

   ////////////////////////////////////////////////////////////////////////////
   // register port

   // writes: only defined bits stick, reserved bits stay zero
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         src_cfg_q <= SRC_CFG_RST;
         drv_cfg_q <= DRV_CFG_RST;
      end
      else if (reg_wr_i)
      begin
         if (reg_addr_i == SRC_CFG_ADDR)
         begin
            src_cfg_q <= reg_wdata_i & SRC_CFG_WMASK;
         end
         if (reg_addr_i == DRV_CFG_ADDR)
         begin
            drv_cfg_q <= reg_wdata_i & DRV_CFG_WMASK;
         end
      end
   end

   // reads: data valid the cycle after the strobe only, zero otherwise
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         rdata_q <= '0;
      end
      else if (reg_rd_i && (reg_addr_i == SRC_CFG_ADDR))
      begin
         rdata_q <= src_cfg_q;
      end
      else if (reg_rd_i && (reg_addr_i == DRV_CFG_ADDR))
      begin
         rdata_q <= drv_cfg_q;
      end
      else
      begin
         rdata_q <= '0; // unmapped address and idle cycles read as zero
      end
   end

   assign reg_rdata_o = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // blink timebase

   assign tb_if.rate = src_cfg_q[RATE_LSB +: 2];

   led_blink_timebase #(
      .HALF_20HZ (HALF_20HZ),
      .HALF_10HZ (HALF_10HZ),
      .HALF_5HZ  (HALF_5HZ),
      .HALF_2HZ  (HALF_2HZ)
   ) u_timebase (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .tb        (tb_if.gen)
   );

   // activity seen flags for trx, tx and rx; cleared at the end of the off
   // half so a single packet still gives one visible dark half period,
   // and a new activity pulse in the clearing cycle wins over the clear
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         act_seen_q <= '0;
      end
      else
      begin
         act_seen_q[0] <= (tx_act_i | rx_act_i) |
                          (act_seen_q[0] & ~(tb_if.blink_wrap & ~tb_if.blink_phase));
         act_seen_q[1] <= tx_act_i |
                          (act_seen_q[1] & ~(tb_if.blink_wrap & ~tb_if.blink_phase));
         act_seen_q[2] <= rx_act_i |
                          (act_seen_q[2] & ~(tb_if.blink_wrap & ~tb_if.blink_phase));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pulse stretchers: index 0 activity, index 1 mac interface errors

   assign bypass     = src_cfg_q[BYPASS_BIT];
   assign str_evt[0] = tx_act_i | rx_act_i;
   assign str_evt[1] = mac_tx_err_i | mac_rx_err_i;

   // each event reloads the hold count, so bursts merge into one long pulse
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         str_cnt_q[0] <= '0;
         str_cnt_q[1] <= '0;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (str_evt[i])
            begin
               str_cnt_q[i] <= CNT_W'(STRETCH_LEN - 1);
            end
            else if (str_cnt_q[i] != '0)
            begin
               str_cnt_q[i] <= str_cnt_q[i] - 1'b1;
            end
         end
      end
   end

   // with bypass set the raw event is shown, one-cycle glitches included
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         if (bypass)
         begin
            str_out[i] = str_evt[i];
         end
         else
         begin
            str_out[i] = str_evt[i] | (str_cnt_q[i] != '0);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky indications, a set in the clearing cycle wins

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         link_prev_q  <= 1'b0;
         link_lost_q  <= 1'b0;
         prbs_latch_q <= 1'b0;
      end
      else
      begin
         link_prev_q  <= link_up_i;
         link_lost_q  <= (link_prev_q & ~link_up_i) |
                         (link_lost_q & ~status_read_i);
         prbs_latch_q <= prbs_err_i | (prbs_latch_q & ~prbs_clr_i);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per led source selection

   always_comb
   begin
      for (int i = 0; i < NUM_LEDS; i++)
      begin
         unique case (led_option(src_cfg_q, i))
            SRC_LINK:      led_norm[i] = link_up_i;
            SRC_LINK_TRX:  led_norm[i] = link_blink(link_up_i, act_seen_q[0],
                                                    tb_if.blink_phase);
            SRC_LINK_TX:   led_norm[i] = link_blink(link_up_i, act_seen_q[1],
                                                    tb_if.blink_phase);
            SRC_LINK_RX:   led_norm[i] = link_blink(link_up_i, act_seen_q[2],
                                                    tb_if.blink_phase);
            SRC_MASTER:    led_norm[i] = link_up_i & phy_master_i;
            SRC_SLAVE:     led_norm[i] = link_up_i & ~phy_master_i;
            SRC_ACT_STR:   led_norm[i] = str_out[0];
            SRC_LINK_LOST: led_norm[i] = link_lost_q;
            SRC_PRBS_ERR:  led_norm[i] = prbs_latch_q;
            SRC_MAC_ERR:   led_norm[i] = str_out[1];
            default:       led_norm[i] = 1'b0; // reserved codes keep the led dark
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // compliance observation on led 0

   assign compl_sel = drv_cfg_q[COMPL_LSB +: 3];

   // codes beyond the six signals give a dark pin rather than a stale one
   always_comb
   begin
      if (compl_sel < 3'(NUM_COMPL))
      begin
         compl_bit = compl_status_i[compl_sel];
      end
      else
      begin
         compl_bit = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // manual override, compliance substitution and polarity

   always_comb
   begin
      for (int i = 0; i < NUM_LEDS; i++)
      begin
         if (drv_bit(drv_cfg_q, i, EN_OFS))
         begin
            led_d[i] = drv_bit(drv_cfg_q, i, VAL_OFS);
         end
         else
         begin
            led_d[i] = led_norm[i];
         end
         if ((i == 0) && (led0_mux_ctrl_i == MUX_COMPLIANCE))
         begin
            led_d[i] = compl_bit;
         end
         led_d[i] = led_d[i] ^ drv_bit(drv_cfg_q, i, POL_OFS);
      end
   end

   // registered pins: one cycle of latency buys glitch-free outputs
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         led_q <= '0;
      end
      else
      begin
         led_q <= led_d;
      end
   end

   assign led_o = led_q;

endmodule : led_indicator_config

// ==== led_indicator_config_properties.sv ====
// concurrent checks on the led indicator configuration ports
`timescale 1ns/1ns
module led_indicator_config_properties
   import led_cfg_pkg::*;
#(
   parameter int STRETCH_LEN = STRETCH_CYC
) (
   input wire logic        clk_sys_i,
   input wire logic        rst_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        link_up_i,
   input wire logic        phy_master_i,
   input wire logic        status_read_i,
   input wire logic        prbs_err_i,
   input wire logic        mac_tx_err_i,
   input wire logic        mac_rx_err_i,
   input wire logic [5:0]  compl_status_i,
   input wire logic [2:0]  led0_mux_ctrl_i,
   input wire logic [2:0]  led_o
);
   logic [15:0] src_q;
   logic [15:0] drv_q;
   int          str_q;
   logic        plain1;
   logic        exp1;
   logic        cmp0;
   logic        lost_cfg;

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   ////////////////////////////////////////////////////////////////////////
   // shadow copies of both config registers, so checks need no hierarchy
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         src_q <= SRC_CFG_RST;
         drv_q <= DRV_CFG_RST;
      end
      else if (reg_wr_i && reg_addr_i == SRC_CFG_ADDR)
         src_q <= reg_wdata_i & SRC_CFG_WMASK;
      else if (reg_wr_i && reg_addr_i == DRV_CFG_ADDR)
         drv_q <= reg_wdata_i & DRV_CFG_WMASK;
   end

   // stretch window: event cycle plus the remaining count
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         str_q <= 0;
      else if (mac_tx_err_i || mac_rx_err_i)
         str_q <= STRETCH_LEN - 1;
      else if (str_q != 0)
         str_q <= str_q - 1;
   end

   // expected levels of the sources that have no timing of their own
   always_comb
   begin
      plain1 = !(src_q[7:4] inside {4'h1, 4'h2, 4'h3, 4'h6, 4'h9, 4'ha, 4'hb});
      case (src_q[7:4])
         SRC_LINK:   exp1 = link_up_i;
         SRC_MASTER: exp1 = link_up_i & phy_master_i;
         SRC_SLAVE:  exp1 = link_up_i & ~phy_master_i;
         default:    exp1 = 1'b0;
      endcase
      exp1 = exp1 ^ drv_q[3];
      cmp0 = drv_q[0] ^ ((drv_q[11:9] < 3'h6) ? compl_status_i[drv_q[11:9]] : 1'b0);
      lost_cfg = src_q[11:8] == SRC_LINK_LOST && drv_q[8:6] == 3'h0;
   end

   ////////////////////////////////////////////////////////////////////////
   led0_manual_a:
      assert property (drv_q[2] && led0_mux_ctrl_i != MUX_COMPLIANCE |=> led_o[0] == ($past(drv_q[1]) ^ $past(drv_q[0])))
      else $error("led 0 manual level wrong");
   led2_manual_a:
      assert property (drv_q[8] |=> led_o[2] == ($past(drv_q[7]) ^ $past(drv_q[6])))
      else $error("led 2 manual level wrong");
   compl_route_a:
      assert property (led0_mux_ctrl_i == MUX_COMPLIANCE |=> led_o[0] == $past(cmp0))
      else $error("led 0 compliance level wrong");
   plain_src_a:
      assert property (plain1 && !drv_q[5] |=> led_o[1] == $past(exp1))
      else $error("led 1 plain source wrong");
   lost_set_a:
      assert property (lost_cfg && $fell(link_up_i) |-> ##[1:3] led_o[2])
      else $error("led 2 missed link loss");
   lost_hold_a:
      assert property (lost_cfg && $past(lost_cfg) && led_o[2] && !status_read_i && !$past(status_read_i) |=> led_o[2])
      else $error("led 2 loss latch dropped");
   prbs_set_a:
      assert property (src_q[3:0] == SRC_PRBS_ERR && drv_q[2:0] == 3'h0 && led0_mux_ctrl_i != MUX_COMPLIANCE && prbs_err_i |-> ##[1:2] led_o[0])
      else $error("led 0 missed prbs error");
   err_stretch_a:
      assert property (src_q[3:0] == SRC_MAC_ERR && drv_q[2:0] == 3'h0 && !src_q[14] && led0_mux_ctrl_i != MUX_COMPLIANCE && (mac_tx_err_i || mac_rx_err_i || str_q != 0) |=> led_o[0])
      else $error("led 0 error not stretched");
endmodule : led_indicator_config_properties

bind led_indicator_config led_indicator_config_properties #(.STRETCH_LEN(STRETCH_LEN)) i_props (
   .clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .link_up_i, .phy_master_i,
   .status_read_i, .prbs_err_i, .mac_tx_err_i, .mac_rx_err_i, .compl_status_i,
   .led0_mux_ctrl_i, .led_o
);

// ==== led_board_monitor.sv ====
// board-side blink meter watching led pin 0
`timescale 1ns/1ns
module led_board_monitor (
   input  wire logic       clk_sys_i,
   input  wire logic [2:0] led_i,
   output int              period_o
);
   int   cnt_q;
   logic prev_q;

   // cycles between two rising edges of led 0; only valid once two edges were seen
   always_ff @(posedge clk_sys_i)
   begin
      prev_q <= led_i[0];
      cnt_q  <= (led_i[0] && !prev_q) ? 1 : cnt_q + 1;
      if (led_i[0] && !prev_q)
         period_o <= cnt_q;
   end
endmodule : led_board_monitor

// ==== led_indicator_config_test.sv ====
// self-checking testbench of the led indicator configuration block
`timescale 1ns/1ns
module led_indicator_config_test;
   import led_cfg_pkg::*;
   localparam int         half_c [4] = '{4, 8, 16, 32};
   localparam logic [3:0] code_c [6] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
   logic        clk_sys_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic        link_up_i = 1'b1, tx_act_i = 1'b0, rx_act_i = 1'b0, phy_master_i = 1'b0;
   logic        status_read_i = 1'b0, prbs_err_i = 1'b0, prbs_clr_i = 1'b0, l;
   logic        mac_tx_err_i = 1'b0, mac_rx_err_i = 1'b0, rd_prev = 1'b0;
   logic [15:0] reg_addr_i = 16'h0000, reg_wdata_i = 16'h0000, reg_rdata_o, d;
   logic [5:0]  compl_status_i = 6'h00;
   logic [2:0]  led0_mux_ctrl_i = 3'h0, led_o, x;
   logic [15:0] rd_q [$];
   logic [32:0] ob_q [$];
   logic [32:0] e;
   int          fails = 0, cmp_count = 0, period, k, seed = 32'h97476163;

   led_indicator_config #(.HALF_20HZ(half_c[0]), .HALF_10HZ(half_c[1]), .HALF_5HZ(half_c[2]),
      .HALF_2HZ(half_c[3]), .STRETCH_LEN(5)) i_dut (
      .clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
      .link_up_i, .tx_act_i, .rx_act_i, .phy_master_i, .status_read_i, .prbs_err_i,
      .prbs_clr_i, .mac_tx_err_i, .mac_rx_err_i, .compl_status_i, .led0_mux_ctrl_i, .led_o);
   led_board_monitor i_mon (.clk_sys_i, .led_i(led_o), .period_o(period));

   initial
   begin
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : tick
   // bus cycles keep one idle cycle after the strobe so no signal is set twice at an edge
   task automatic wr(input logic [15:0] a, input logic [15:0] v);
      reg_addr_i  <= a;
      reg_wdata_i <= v;
      reg_wr_i    <= 1'b1;
      tick(1);
      reg_wr_i    <= 1'b0;
      tick(1);
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [15:0] v);
      rd_q.push_back(v);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      tick(1);
      reg_rd_i   <= 1'b0;
      tick(1);
   endtask : rd
   task automatic exp_led(input logic [2:0] v);
      ob_q.push_back({30'h0, v});
      tick(1);
   endtask : exp_led
   task automatic check(input string n, input logic [31:0] v, input logic [31:0] g);
      cmp_count++;
      if (g !== v)
      begin
         fails++;
         $display("FAIL %s expected %h seen %h", n, v, g);
      end
   endtask : check
   // one compare task for each kind of result
   task automatic check_rdata(input logic [15:0] v, input logic [15:0] g);
      check("rdata", {16'h0, v}, {16'h0, g});
   endtask : check_rdata
   task automatic check_led(input logic [2:0] v, input logic [2:0] g);
      check("led", {29'h0, v}, {29'h0, g});
   endtask : check_led
   task automatic check_period(input logic [31:0] v, input logic [31:0] g);
      check("period", v, g);
   endtask : check_period
   task automatic done(input string n);
      $display("test %s finished", n);
   endtask : done
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize

   // takes the oldest note off a queue mid-cycle, where outputs are settled
   always @(negedge clk_sys_i)
   begin
      if (rd_prev)
         check_rdata(rd_q.pop_front(), reg_rdata_o);
      if (ob_q.size() > 0)
      begin
         e = ob_q.pop_front();
         if (e[32])
            check_period(e[31:0], period);
         else
            check_led(e[2:0], led_o);
      end
      rd_prev = reg_rd_i;
   end

   // hang guard, far above the length of the whole run
   initial
   begin
      repeat (20000) @(posedge clk_sys_i);
      fails++;
      summarize();
   end

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      tick(20);
      rst_i <= 1'b0;
      tick(1);
      rd(SRC_CFG_ADDR, SRC_CFG_RST);
      rd(DRV_CFG_ADDR, DRV_CFG_RST);
      wr(SRC_CFG_ADDR, 16'hffff);
      wr(DRV_CFG_ADDR, 16'hffff);
      wr(16'h0452, 16'hffff);
      rd(SRC_CFG_ADDR, SRC_CFG_WMASK);
      rd(DRV_CFG_ADDR, DRV_CFG_WMASK);
      rd(16'h0452, 16'h0000);
      done("registers");
      // random manual drive, value and polarity over plain link sources
      wr(SRC_CFG_ADDR, 16'h0000);
      for (k = 0; k < 12; k++)
      begin
         d = 16'($random(seed)) & 16'h01ff;
         l = 1'($random(seed));
         link_up_i <= l;
         wr(DRV_CFG_ADDR, d);
         for (int i = 0; i < 3; i++)
            x[i] = (d[3*i+2] ? d[3*i+1] : l) ^ d[3*i];
         exp_led(x);
      end
      done("manual");
      wr(DRV_CFG_ADDR, 16'h0000);
      link_up_i <= 1'b1;
      foreach (code_c[j])
         for (k = 0; k < 2; k++)
         begin
            phy_master_i <= k[0];
            wr(SRC_CFG_ADDR, {8'h00, code_c[j], 4'h0});
            x[1] = code_c[j] == 4'h0 || (code_c[j] == 4'h4 && k[0]) || (code_c[j] == 4'h5 && !k[0]);
            exp_led({1'b1, x[1], 1'b1});
         end
      done("sources");
      // compliance routing wins over the manual drive of led 0
      wr(SRC_CFG_ADDR, 16'h0000);
      led0_mux_ctrl_i <= MUX_COMPLIANCE;
      for (k = 0; k < 8; k++)
      begin
         d = 16'($random(seed));
         compl_status_i <= d[5:0];
         wr(DRV_CFG_ADDR, {4'h0, k[2:0], 9'h004});
         exp_led({2'b11, (k < 6) ? d[k] : 1'b0});
      end
      led0_mux_ctrl_i <= 3'h0;
      wr(DRV_CFG_ADDR, 16'h0000);
      done("compliance");
      tx_act_i <= 1'b1;
      rx_act_i <= 1'b1;
      for (k = 0; k < 4; k++)
      begin
         wr(SRC_CFG_ADDR, {2'b00, k[1:0], 12'h321});
         tick(6 * half_c[k]);
         ob_q.push_back({1'b1, 32'(2 * half_c[k])});
         tick(1);
      end
      // one direction at a time: the idle direction's source must stay lit
      // over two samples half a period apart, the others are forced dark
      for (k = 0; k < 2; k++)
      begin
         tx_act_i <= k[0];
         rx_act_i <= !k[0];
         wr(DRV_CFG_ADDR, k[0] ? 16'h0024 : 16'h0104);
         tick(4 * half_c[3]);
         exp_led(k[0] ? 3'b100 : 3'b010);
         tick(half_c[3] - 1);
         exp_led(k[0] ? 3'b100 : 3'b010);
      end
      tx_act_i <= 1'b0;
      rx_act_i <= 1'b0;
      wr(DRV_CFG_ADDR, 16'h0000);
      tick(8 * half_c[3]);
      exp_led(3'h7);
      done("blink");
      // both latches: set, held, then cleared by their own pulse
      status_read_i <= 1'b1;
      tick(1);
      status_read_i <= 1'b0;
      wr(SRC_CFG_ADDR, 16'h090a);
      exp_led(3'b010);
      link_up_i <= 1'b0;
      tick(1);
      link_up_i <= 1'b1;
      tick(4);
      exp_led(3'b110);
      tick(4);
      exp_led(3'b110);
      status_read_i <= 1'b1;
      tick(1);
      status_read_i <= 1'b0;
      tick(3);
      exp_led(3'b010);
      prbs_err_i <= 1'b1;
      tick(1);
      prbs_err_i <= 1'b0;
      tick(4);
      exp_led(3'b011);
      prbs_clr_i <= 1'b1;
      tick(1);
      prbs_clr_i <= 1'b0;
      tick(3);
      exp_led(3'b010);
      done("latches");
      for (k = 0; k < 2; k++)
      begin
         wr(SRC_CFG_ADDR, {1'b0, k[0], 14'h000b});
         mac_tx_err_i <= !k[0];
         mac_rx_err_i <= k[0];
         tick(1);
         mac_tx_err_i <= 1'b0;
         mac_rx_err_i <= 1'b0;
         for (int j = 0; j < 7; j++)
            exp_led({2'b11, j < (k[0] ? 1 : 5)});
      end
      done("stretch");
      summarize();
   end
endmodule : led_indicator_config_test
